// [src/fpf_regs.vh]
`ifndef FPF_REGS_VH
`define FPF_REGS_VH
// ==========================================
// register offsets
`define FPF_ADDR_W           8
`define FPF_OFF_GEOMETRY     8'h0c
`define FPF_OFF_REVISION     8'h10
`define FPF_OFF_FUSE_UPPER   8'h14
`define FPF_OFF_FUSE_LOWER   8'h18
`define FPF_OFF_USER_WORD0   8'h1c
`define FPF_OFF_USER_WORD1   8'h20
// ==========================================
// field positions
`define FPF_PSZ_HI           10
`define FPF_PSZ_LO           8
`define FPF_FSZ_HI           3
`define FPF_FSZ_LO           0
`define FPF_VER_HI           11
`define FPF_VER_LO           0
`define FPF_BROWNOUT_ENABLE_FIELD_HI         31
`define FPF_BROWNOUT_ENABLE_FIELD_LO         30
`define FPF_BROWNOUT_HYSTERESIS_BIT      29
`define FPF_LVL_UP_HI        28
`define FPF_LVL_UP_LO        24
`define FPF_LVL_LOW_BIT      23
`define FPF_USER_PAGE_PROTECT_BIT        22
`define FPF_SECURE_HI        21
`define FPF_SECURE_LO        20
`define FPF_BOOT_AREA_PROTECT_SIZE_HI      19
`define FPF_BOOT_AREA_PROTECT_SIZE_LO      17
`define FPF_EXT_PRIV_FETCH_LOCK_BIT         16
`define FPF_LOCK_HI          15
`define FPF_LOCK_LO          0
`define FPF_WDT_BIT          0
`define FPF_SRAM_HI          31
`define FPF_SRAM_LO          16
`define FPF_SFLASH_HI        15
`define FPF_SFLASH_LO        0
// ==========================================
// values
`define FPF_ZERO32           32'h00000000
`define FPF_ONES32           32'hffffffff
`define FPF_FUSE_SHIPPED     32'he077ffff
`define FPF_BOD_OFF          2'h0
`define FPF_BOD_RESET        2'h1
`define FPF_BOD_NORESET      2'h2
`define FPF_FSZ_RSVD         4'hf
`define FPF_PSZ_DEFAULT      3'h3
`define FPF_FSZ_DEFAULT      4'h5
`define FPF_VER_DEFAULT      12'h001
`endif

// [src/fpf_readout.v]
// Function
// R01: page size reads as a 3-bit code where 0 is 32 bytes, each step doubles, 7 is 4096 bytes.
// R02: flash size reads as a 4-bit code from 4K up to 2048K bytes with code 15 reserved.
// R03: the revision register carries a 12-bit version in its low bits with no effect on behaviour.
// R04: the variant field is reserved, reads zero and nothing acts on it.
// R05: each fuse bit reads 1 when erased and 0 when programmed.
// R06: 32 fuses read in the lower fuse register and the upper fuse register is unused.
// R07: a debug chip erase sets every fuse so the lower register reads all ones.
// R08: the brown-out enable field decodes 00 off, 01 on with reset, 10 on without reset, 11 reserved.
// R09: the hysteresis fuse enables hysteresis when 1 and disables it when 0.
// R10: the 6-bit trigger level joins five upper bits with the adjacent lowest bit.
// R11: protect, security, boot-protect, fetch-lock and 16 lock bits feed the controller.
// R12: an erased lock fuse leaves its region unlocked.
// R13: as shipped the lower fuse word holds the documented default value.
// R14: bit 0 of user word 0 low enables the watchdog at startup, high leaves it off.
// R15: user word 1 holds the secure RAM end in its upper half and flash end in its lower half.
// R16: the user row ships erased so the watchdog does not start automatically.
// R17: writes to the geometry, revision and fuse registers are ignored.
//
// Strobed register access is this design's own decision.

// macros must be visible before the parameter defaults use them
`include "fpf_regs.vh"

module fpf_readout #(
  parameter [2:0]  PAGE_SIZE_CODE  = `FPF_PSZ_DEFAULT,
  parameter [3:0]  FLASH_SIZE_CODE = `FPF_FSZ_DEFAULT,
  // arbitrary neutral revision value
  parameter [11:0] REVISION        = `FPF_VER_DEFAULT
) (
  // clock and reset
  input  wire        clk_in,
  input  wire        rst_in,
  // register port
  input  wire [7:0]  addr_in,
  input  wire [31:0] wdata_in,
  input  wire        wr_in,
  input  wire        rd_in,
  output reg  [31:0] rdata_out,
  // fuse programming from the command engine
  input  wire        fuse_prog_in,
  input  wire        fuse_erase_in,
  input  wire [4:0]  fuse_index_in,
  input  wire        chip_erase_in,
  input  wire        user_row_we_in,
  input  wire        user_row_sel_in,
  input  wire [31:0] user_row_data_in,
  input  wire        user_row_erase_in,
  // decoded fuse outputs
  output reg         brownout_enable_out,
  output reg         brownout_reset_out,
  output reg         brownout_hysteresis_out,
  output reg  [5:0]  brownout_trigger_level_out,
  output reg         user_page_protect_out,
  output reg  [1:0]  security_out,
  output reg  [2:0]  boot_area_protect_size_out,
  output reg         ext_priv_fetch_lock_out,
  output reg  [15:0] region_locked_out,
  output reg         watchdog_autostart_out,
  output reg  [15:0] secure_ram_end_addr_out,
  output reg  [15:0] secure_flash_end_addr_out
);

  // ==========================================
  // storage
  reg [31:0] fuse_reg;
  reg [31:0] fuse_next;
  reg [31:0] user0_reg;
  reg [31:0] user1_reg;
  reg [31:0] rdata_next;

  // fuse cells are flops here; shipped value stands in for the array
  always @* begin
    fuse_next = fuse_reg;
    if (fuse_prog_in) begin
      fuse_next[fuse_index_in] = 1'b0; // [R05]
    end
    if (fuse_erase_in) begin
      fuse_next[fuse_index_in] = 1'b1; // [R05]
    end
    if (chip_erase_in) begin
      fuse_next = `FPF_ONES32; // [R07]
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      fuse_reg <= `FPF_FUSE_SHIPPED; // [R13]
    end else begin
      fuse_reg <= fuse_next; // [R17]
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      user0_reg <= `FPF_ONES32; // [R16]
      user1_reg <= `FPF_ONES32; // [R16]
    end else if (user_row_erase_in || chip_erase_in) begin
      user0_reg <= `FPF_ONES32;
      user1_reg <= `FPF_ONES32;
    end else if (user_row_we_in) begin
      // flash write can only clear bits
      if (user_row_sel_in) begin
        user1_reg <= user1_reg & user_row_data_in;
      end else begin
        user0_reg <= user0_reg & user_row_data_in;
      end
    end
  end

  // ==========================================
  // register read
  always @* begin
    rdata_next = `FPF_ZERO32;
    case (addr_in)
      `FPF_OFF_GEOMETRY: begin
        rdata_next[`FPF_PSZ_HI:`FPF_PSZ_LO] = PAGE_SIZE_CODE; // [R01]
        rdata_next[`FPF_FSZ_HI:`FPF_FSZ_LO] = FLASH_SIZE_CODE; // [R02]
      end
      `FPF_OFF_REVISION: begin
        rdata_next[`FPF_VER_HI:`FPF_VER_LO] = REVISION; // [R03] [R04]
      end
      `FPF_OFF_FUSE_UPPER: rdata_next = `FPF_ZERO32; // [R06]
      `FPF_OFF_FUSE_LOWER: rdata_next = fuse_reg; // [R06] [R05]
      `FPF_OFF_USER_WORD0: rdata_next = user0_reg;
      `FPF_OFF_USER_WORD1: rdata_next = user1_reg;
      default:             rdata_next = `FPF_ZERO32;
    endcase
  end

  // data valid only in the cycle after the strobe
  always @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= `FPF_ZERO32;
    end else if (rd_in) begin
      rdata_out <= rdata_next;
    end else begin
      rdata_out <= `FPF_ZERO32;
    end
  end

  // ==========================================
  // decoded fuse outputs
  always @(posedge clk_in) begin
    if (rst_in) begin
      brownout_enable_out        <= 1'b0;
      brownout_reset_out         <= 1'b0;
      brownout_hysteresis_out    <= 1'b0;
      brownout_trigger_level_out <= 6'h00;
      user_page_protect_out      <= 1'b0;
      security_out               <= 2'h0;
      boot_area_protect_size_out <= 3'h0;
      ext_priv_fetch_lock_out    <= 1'b0;
      region_locked_out          <= 16'h0000;
      watchdog_autostart_out     <= 1'b0;
      secure_ram_end_addr_out    <= 16'h0000;
      secure_flash_end_addr_out  <= 16'h0000;
    end else begin
      // reserved 11 treated as disabled
      brownout_enable_out <=
        (fuse_reg[`FPF_BROWNOUT_ENABLE_FIELD_HI:`FPF_BROWNOUT_ENABLE_FIELD_LO] == `FPF_BOD_RESET) ||
        (fuse_reg[`FPF_BROWNOUT_ENABLE_FIELD_HI:`FPF_BROWNOUT_ENABLE_FIELD_LO] == `FPF_BOD_NORESET); // [R08]
      brownout_reset_out <=
        (fuse_reg[`FPF_BROWNOUT_ENABLE_FIELD_HI:`FPF_BROWNOUT_ENABLE_FIELD_LO] == `FPF_BOD_RESET); // [R08]
      brownout_hysteresis_out <= fuse_reg[`FPF_BROWNOUT_HYSTERESIS_BIT]; // [R09]
      brownout_trigger_level_out <= {fuse_reg[`FPF_LVL_UP_HI:`FPF_LVL_UP_LO],
                                     fuse_reg[`FPF_LVL_LOW_BIT]}; // [R10]
      user_page_protect_out <= fuse_reg[`FPF_USER_PAGE_PROTECT_BIT]; // [R11]
      security_out <= fuse_reg[`FPF_SECURE_HI:`FPF_SECURE_LO]; // [R11]
      boot_area_protect_size_out <= fuse_reg[`FPF_BOOT_AREA_PROTECT_SIZE_HI:`FPF_BOOT_AREA_PROTECT_SIZE_LO]; // [R11]
      ext_priv_fetch_lock_out <= ~fuse_reg[`FPF_EXT_PRIV_FETCH_LOCK_BIT]; // [R11]
      region_locked_out <= ~fuse_reg[`FPF_LOCK_HI:`FPF_LOCK_LO]; // [R12]
      watchdog_autostart_out <= ~user0_reg[`FPF_WDT_BIT]; // [R14]
      secure_ram_end_addr_out <= user1_reg[`FPF_SRAM_HI:`FPF_SRAM_LO]; // [R15]
      secure_flash_end_addr_out <= user1_reg[`FPF_SFLASH_HI:`FPF_SFLASH_LO]; // [R15]
    end
  end

endmodule

// [sim/fpf_readout_props.sv]
// ====
// read-back relations at the register port
module fpf_readout_props #(
  parameter [2:0]  PAGE_SIZE_CODE  = 3'h3,
  parameter [3:0]  FLASH_SIZE_CODE = 4'h5,
  parameter [11:0] REVISION        = 12'h001
) (
  input logic        clk_in, rst_in, rd_in, fuse_prog_in, chip_erase_in,
  input logic [7:0]  addr_in,
  input logic [31:0] rdata_out,
  input logic        brownout_enable_out, brownout_reset_out, brownout_hysteresis_out,
  input logic [5:0]  brownout_trigger_level_out,
  input logic [15:0] region_locked_out,
  input logic        watchdog_autostart_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_geom; rd_in && addr_in == 8'h0c |=>
    rdata_out == {21'h0, PAGE_SIZE_CODE, 4'h0, FLASH_SIZE_CODE}; endproperty
  a_geom: assert property (p_geom) else $error("geometry word wrong");
  property p_rev; rd_in && addr_in == 8'h10 |=> rdata_out == {20'h0, REVISION}; endproperty
  a_rev: assert property (p_rev) else $error("revision word wrong");
  property p_up; rd_in && addr_in == 8'h14 |=> rdata_out == 32'h0; endproperty
  a_up: assert property (p_up) else $error("upper fuse word nonzero");
  // a program just after the erase would clear a bit again
  property p_ce; chip_erase_in ##1 !fuse_prog_in ##[0:1] (rd_in && addr_in == 8'h18)
    |=> rdata_out == 32'hffffffff; endproperty
  a_ce: assert property (p_ce) else $error("fuses not erased");
  property p_lk; rd_in && addr_in == 8'h18 |=> region_locked_out == ~rdata_out[15:0];
  endproperty
  a_lk: assert property (p_lk) else $error("region lock decode wrong");
  property p_be; rd_in && addr_in == 8'h18 |=> {brownout_enable_out, brownout_reset_out}
    == {rdata_out[31] ^ rdata_out[30], rdata_out[31:30] == 2'h1}; endproperty
  a_be: assert property (p_be) else $error("brownout enable decode wrong");
  property p_lv; rd_in && addr_in == 8'h18 |=>
    {brownout_hysteresis_out, brownout_trigger_level_out} == rdata_out[29:23]; endproperty
  a_lv: assert property (p_lv) else $error("hysteresis or level wrong");
  property p_wd; rd_in && addr_in == 8'h1c |=> watchdog_autostart_out == !rdata_out[0];
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog autostart wrong");
endmodule
bind fpf_readout fpf_readout_props #(.PAGE_SIZE_CODE(PAGE_SIZE_CODE),
  .FLASH_SIZE_CODE(FLASH_SIZE_CODE), .REVISION(REVISION)) i_fpf_readout_props (.*);

// [sim/fpf_readout_test.sv]
// ====
// bench
module fpf_readout_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, fuse_prog_in = 0, fuse_erase_in = 0;
  logic chip_erase_in = 0, user_row_we_in = 0, user_row_sel_in = 0, user_row_erase_in = 0;
  logic [7:0] addr_in = 0;
  logic [4:0] fuse_index_in = 0;
  logic [31:0] wdata_in = 0, user_row_data_in = 0, rdata_out;
  logic brownout_enable_out, brownout_reset_out, brownout_hysteresis_out, user_page_protect_out;
  logic ext_priv_fetch_lock_out, watchdog_autostart_out;
  logic [5:0] brownout_trigger_level_out;
  logic [1:0] security_out;
  logic [2:0] boot_area_protect_size_out;
  logic [15:0] region_locked_out, secure_ram_end_addr_out, secure_flash_end_addr_out;
  int fails = 0, checks_done = 0;
  // boundary codes so the geometry fields cannot hide behind defaults
  fpf_readout #(.PAGE_SIZE_CODE(3'h7), .FLASH_SIZE_CODE(4'he), .REVISION(12'habc))
    i_fpf_readout (.*);
  always #2.5 clk_in = ~clk_in;
  task ck(input string n, input logic [31:0] e, v);
    checks_done++;
    if (v !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, v);
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clk_in) {addr_in, rd_in} <= {a, 1'b1};
    @(posedge clk_in) rd_in <= 1'b0;
    #1 ck(n, e, rdata_out);
  endtask
  task fz(input logic p, e, input logic [4:0] i);
    @(posedge clk_in) {fuse_prog_in, fuse_erase_in, fuse_index_in} <= {p, e, i};
    @(posedge clk_in) {fuse_prog_in, fuse_erase_in} <= 2'h0;
  endtask
  task t_ship;
    rd(8'h0c, 32'h0000070e, "geom");
    rd(8'h10, 32'h00000abc, "rev");
    rd(8'h14, 32'h0, "upper");
    rd(8'h18, 32'he077ffff, "lower");
    ck("decode", 32'h04060000, {brownout_enable_out, brownout_hysteresis_out,
      brownout_trigger_level_out, boot_area_protect_size_out, ext_priv_fetch_lock_out,
      region_locked_out});
    ck("prot", 32'h7, {user_page_protect_out, security_out});
    rd(8'h1c, 32'hffffffff, "user0");
    ck("wdt", 32'h0, watchdog_autostart_out);
    rd(8'h20, 32'hffffffff, "user1");
    rd(8'h04, 32'h0, "unmapped");
  endtask
  task t_wr;
    @(posedge clk_in) {addr_in, wr_in} <= {8'h18, 1'b1};
    @(posedge clk_in) wr_in <= 1'b0;
    rd(8'h18, 32'he077ffff, "written");
  endtask
  task t_bo;
    fz(1, 0, 5'h1f);
    rd(8'h18, 32'h6077ffff, "f01");
    ck("en01", 32'h3, {brownout_enable_out, brownout_reset_out});
    fz(0, 1, 5'h1f);
    fz(1, 0, 5'h1e);
    rd(8'h18, 32'ha077ffff, "f10");
    ck("en10", 32'h2, {brownout_enable_out, brownout_reset_out});
    fz(1, 0, 5'h1f);
    rd(8'h18, 32'h2077ffff, "f00");
    ck("en00", 32'h0, {brownout_enable_out, brownout_reset_out});
  endtask
  task t_lock;
    fz(1, 0, 5'h03);
    fz(1, 0, 5'h1d);
    fz(0, 1, 5'h17);
    fz(0, 1, 5'h1c);
    fz(1, 0, 5'h10);
    rd(8'h18, 32'h10f6fff7, "fuses");
    ck("lvl", 32'h21, {brownout_hysteresis_out, brownout_trigger_level_out});
    ck("lock", 32'h10008, {ext_priv_fetch_lock_out, region_locked_out});
  endtask
  task ur(input logic s, input logic [31:0] d);
    @(posedge clk_in) {user_row_we_in, user_row_sel_in, user_row_data_in} <= {1'b1, s, d};
    @(posedge clk_in) user_row_we_in <= 1'b0;
  endtask
  task t_user;
    ur(0, 32'hfffffffe);
    rd(8'h1c, 32'hfffffffe, "user0");
    ck("wdt", 32'h1, watchdog_autostart_out);
    ur(1, 32'h12345678);
    rd(8'h20, 32'h12345678, "user1");
    ck("ends", 32'h12345678, {secure_ram_end_addr_out, secure_flash_end_addr_out});
    @(posedge clk_in) user_row_erase_in <= 1'b1;
    @(posedge clk_in) user_row_erase_in <= 1'b0;
    rd(8'h20, 32'hffffffff, "user1 erased");
    ur(0, 32'hfffffffe);
  endtask
  task t_erase;
    @(posedge clk_in) chip_erase_in <= 1'b1;
    @(posedge clk_in) chip_erase_in <= 1'b0;
    rd(8'h18, 32'hffffffff, "erased");
    ck("lock", 32'h0, region_locked_out);
    rd(8'h1c, 32'hffffffff, "user0 erased");
    ck("wdt", 32'h0, watchdog_autostart_out);
  endtask
  task test_done;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    t_ship;
    t_wr;
    t_bo;
    t_lock;
    t_user;
    t_erase;
    test_done;
  end
endmodule
